// file: rtl/pfs_defs.vh
// Constants of the point-of-load fault supervisor: register map, fields, reset values, limits and timing.
// Assumes a 100 MHz core clock; every count below is derived from a time and this period.
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define PFS_OFF_CTRL      8'h00
`define PFS_OFF_OC_CFG    8'h04
`define PFS_OFF_OV_CFG    8'h08
`define PFS_OFF_UV_CFG    8'h0C
`define PFS_OFF_LATCH_CFG 8'h10
`define PFS_OFF_STATUS    8'h14
`define PFS_OFF_INT_STAT  8'h18
`define PFS_OFF_INT_MASK  8'h1C

// ==========================================================================
// Fields and reset values
`define PFS_CTRL_RESTART  0
`define PFS_CTRL_TRK_EN   1
`define PFS_CTRL_PG_SEL   2
`define PFS_OC_SEL_RST    4'hA
`define PFS_OC_SEL_MAX    4'hA
`define PFS_OV_SEL_RST    2'h2
`define PFS_OV_SEL_MAX    2'h2
`define PFS_UV_SEL_RST    2'h0
`define PFS_LATCH_RST     5'h00
`define PFS_EV_OC         0
`define PFS_EV_OV         1
`define PFS_EV_UV         2
`define PFS_EV_OT         3
`define PFS_EV_TRK        4
`define PFS_EV_WARN       5

// ==========================================================================
// Limits (percent, degrees Celsius, millivolts)
`define PFS_OC_PCT_BASE   8'h28
`define PFS_OV_PCT_BASE   8'h6E
`define PFS_UV_PCT_BASE   8'h4B
`define PFS_PG_LO_PCT     8'h5A
`define PFS_PG_LO_ALT_PCT 8'h5F
`define PFS_PG_HI_PCT     8'h6E
`define PFS_OV_MIN_MV     12'h3E8
`define PFS_TRK_WIN_MV    13'h0FA
`define PFS_OT_TRIP_C     8'h78
`define PFS_OT_REL_C      8'h6E
`define PFS_WARN_HYST_C   8'h03

// ==========================================================================
// Timing
`define PFS_CLK_NS        10
`define PFS_TRIP_DLY_NS   6000
`define PFS_OT_DLY_NS     2000000
`define PFS_RETRY_NS      130000000
`define PFS_CYC_UP(ns)    (((ns) + `PFS_CLK_NS - 1) / `PFS_CLK_NS)

`endif

// file: rtl/pfs_filter.v
// Holds a level and lets it follow its input only after the input has been steady for N cycles.
// Input comes from logic on the same clock.
`default_nettype none

module pfs_filter #(
  parameter             CNT_W = 18,
  parameter [CNT_W-1:0] N     = 600
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire reset,
  // Level in and out
  input  wire din,
  output reg  dout_r
);

  reg [CNT_W-1:0] cnt_r;

  // A glitch shorter than N cycles restarts the count, so it never reaches the output
  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_r  <= {CNT_W{1'b0}};
      dout_r <= 1'b0;
    end else if (din != dout_r) begin
      if (cnt_r == N - 1'b1) begin
        cnt_r  <= {CNT_W{1'b0}};
        dout_r <= din;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end else begin
      cnt_r <= {CNT_W{1'b0}};
    end
  end

endmodule // pfs_filter

`default_nettype wire

// file: rtl/pfs_hyst.v
// Temperature comparator with hysteresis: sets at or above SET_AT, clears at or below CLR_AT.
// Temperature is a signed whole number of degrees on the core clock.
`default_nettype none

module pfs_hyst #(
  parameter signed [7:0] SET_AT = 8'sh78,
  parameter signed [7:0] CLR_AT = 8'sh6E
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              reset,
  // Temperature and result
  input  wire signed [7:0] temp,
  output reg               hot_r
);

  always @(posedge sys_clk) begin
    if (reset) begin
      hot_r <= 1'b0;
    end else if (temp >= SET_AT) begin
      hot_r <= 1'b1;
    end else if (temp <= CLR_AT) begin
      hot_r <= 1'b0;
    end
  end

endmodule // pfs_hyst

`default_nettype wire

// file: rtl/pfs_supervisor.v
// Fault supervisor of a point-of-load converter: trip comparators, turn-off sequencing, warning, power-good, APB.
// Measurements are digitised by logic on sys_clk and need no synchroniser; voltages in mV, temperature in degC.
//
// Contract
// R1 - Overcurrent level 40..140 percent of rated current, eleven steps, resets to 140.
// R2 - Overvoltage level 110..130 percent of set-point in 10 percent steps, resets to 130.
// R3 - Overvoltage level never below one volt absolute.
// R4 - Undervoltage level 75..90 percent of set-point in 5 percent steps, resets to 75.
// R5 - Overvoltage, undervoltage, tracking faults turn converter off six microseconds after crossing.
// R6 - Overtemperature trips at 120 degC; restart allowed only after falling to 110 degC.
// R7 - Overtemperature turn-off follows the trip by at least two milliseconds.
// R8 - Tracking off by default; when on, checks ramp-up only, trips beyond 250 mV.
// R9 - Warning always on; flag sets at 120 degC, clears after 3 degree drop.
// R10 - Warning flag asserts six microseconds after its level is exceeded.
// R11 - Power-good high inside window 90 or 95 up to 110 percent, default 90.
// R12 - Power-good changes state six microseconds after crossing either window edge.
// R13 - Each fault latching or retrying every 130 ms; retrying by default.
`include "pfs_defs.vh"
`default_nettype none

module pfs_supervisor #(
  parameter integer OT_CYC    = `PFS_CYC_UP(`PFS_OT_DLY_NS),
  parameter integer RETRY_CYC = `PFS_CYC_UP(`PFS_RETRY_NS)
) (
  // Clock and reset
  input  wire               sys_clk,
  input  wire               reset,
  // APB slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output reg                pready_r,
  output reg  [31:0]        prdata_r,
  output reg                pslverr_r,
  // Measurements
  input  wire [11:0]        i_meas,
  input  wire [11:0]        i_rated,
  input  wire [11:0]        v_meas,
  input  wire [11:0]        v_set,
  input  wire [11:0]        v_ramp_ref,
  input  wire               ramp_up,
  input  wire signed [7:0]  temp_j,
  // Converter control and signals
  output reg                shutdown_cmd_r,
  output wire               ot_warn_r,
  output wire               window_ok_signal,
  output reg                irq_r
);

  // ==========================================================================
  // Constants
  localparam integer    TRIP_CYC = `PFS_CYC_UP(`PFS_TRIP_DLY_NS);
  localparam [17:0]     TRIP_N   = TRIP_CYC[17:0];
  localparam [17:0]     OT_N     = OT_CYC[17:0];
  localparam [23:0]     RETRY_N  = RETRY_CYC[23:0];
  localparam [19:0]     X100     = 20'h00064;
  localparam [2:0]      ST_RUN   = 3'b001;
  localparam [2:0]      ST_WAIT  = 3'b010;
  localparam [2:0]      ST_LATCH = 3'b100;

  // ==========================================================================
  // Decoding
  function [7:0] reg_sel;
    input [7:0] a;
    begin
      reg_sel = 8'h00;
      case (a)
        `PFS_OFF_CTRL:      reg_sel = 8'h01;
        `PFS_OFF_OC_CFG:    reg_sel = 8'h02;
        `PFS_OFF_OV_CFG:    reg_sel = 8'h04;
        `PFS_OFF_UV_CFG:    reg_sel = 8'h08;
        `PFS_OFF_LATCH_CFG: reg_sel = 8'h10;
        `PFS_OFF_STATUS:    reg_sel = 8'h20;
        `PFS_OFF_INT_STAT:  reg_sel = 8'h40;
        `PFS_OFF_INT_MASK:  reg_sel = 8'h80;
        default:            reg_sel = 8'h00;
      endcase
    end
  endfunction

  // Scales a 12-bit quantity by a percentage to compare against value times 100
  function [19:0] pct_of;
    input [11:0] v;
    input [7:0]  p;
    begin
      pct_of = {8'h00, v} * {12'h000, p};
    end
  endfunction

  // ==========================================================================
  // Registers
  reg        trk_en_r;
  reg        pg_sel_r;
  reg [3:0]  oc_sel_r;
  reg [1:0]  ov_sel_r;
  reg [1:0]  uv_sel_r;
  reg [4:0]  latch_cfg_r;
  reg [5:0]  int_stat_r;
  reg [5:0]  int_mask_r;
  reg [5:0]  flt_d_r;
  reg [4:0]  cause_r;
  reg [2:0]  state_r;
  reg [23:0] retry_cnt_r;

  wire [7:0] sel      = reg_sel(paddr);
  wire       acc      = psel & penable & ~pready_r;
  wire       wr       = psel & penable & pready_r & pwrite;
  wire       restart  = wr & sel[0] & pwdata[`PFS_CTRL_RESTART];

  // ==========================================================================
  // Trip levels
  wire [7:0]  oc_pct   = `PFS_OC_PCT_BASE + {1'b0, oc_sel_r, 3'b000} + {3'b000, oc_sel_r, 1'b0};  // R1
  wire [7:0]  ov_pct   = `PFS_OV_PCT_BASE + {3'b000, ov_sel_r, 3'b000} + {5'h00, ov_sel_r, 1'b0}; // R2
  wire [7:0]  uv_pct   = `PFS_UV_PCT_BASE + {4'h0, uv_sel_r, 2'b00} + {6'h00, uv_sel_r};          // R4
  wire [7:0]  pg_lo    = pg_sel_r ? `PFS_PG_LO_ALT_PCT : `PFS_PG_LO_PCT;                           // R11
  wire [19:0] v_x100   = {8'h00, v_meas} * X100;
  wire [19:0] i_x100   = {8'h00, i_meas} * X100;
  wire [12:0] ref_hi   = {1'b0, v_ramp_ref} + `PFS_TRK_WIN_MV;
  wire [12:0] meas_hi  = {1'b0, v_meas} + `PFS_TRK_WIN_MV;

  // Undervoltage is judged only while the converter runs settled; off or ramping it would trip forever
  wire oc_raw  = i_x100 >= pct_of(i_rated, oc_pct);                                   // R1
  wire ov_raw  = (v_x100 >= pct_of(v_set, ov_pct)) && (v_meas >= `PFS_OV_MIN_MV);     // R3
  wire uv_raw  = (v_x100 <= pct_of(v_set, uv_pct)) && ~shutdown_cmd_r && ~ramp_up;    // R4
  wire trk_raw = trk_en_r & ramp_up & ~shutdown_cmd_r &
                 (({1'b0, v_meas} > ref_hi) || ({1'b0, v_ramp_ref} > meas_hi));      // R8
  wire pg_raw  = (v_x100 >= pct_of(v_set, pg_lo)) && (v_x100 <= pct_of(v_set, `PFS_PG_HI_PCT)); // R11

  // ==========================================================================
  // Qualification delays
  wire q_oc;
  wire q_ov;
  wire q_uv;
  wire q_trk;
  wire q_ot;
  wire ot_hot;
  wire warn_hot;
  wire [4:0] raw_vec = {trk_raw, 1'b0, uv_raw, ov_raw, oc_raw};
  wire [4:0] q_vec;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_trip
      if (g != `PFS_EV_OT) begin : g_fast
        pfs_filter #(.CNT_W(18), .N(TRIP_N)) u_flt (  // R5
          .sys_clk (sys_clk),
          .reset   (reset),
          .din     (raw_vec[g]),
          .dout_r  (q_vec[g])
        );
      end
    end
  endgenerate

  pfs_hyst #(.SET_AT(`PFS_OT_TRIP_C), .CLR_AT(`PFS_OT_REL_C)) u_ot_hyst (  // R6
    .sys_clk (sys_clk),
    .reset   (reset),
    .temp    (temp_j),
    .hot_r   (ot_hot)
  );

  // The long filter also holds the fault for the same time after cooling, which only delays restart
  pfs_filter #(.CNT_W(18), .N(OT_N)) u_ot_flt (  // R7
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (ot_hot),
    .dout_r  (q_vec[`PFS_EV_OT])
  );

  pfs_hyst #(.SET_AT(`PFS_OT_TRIP_C), .CLR_AT(`PFS_OT_TRIP_C - `PFS_WARN_HYST_C)) u_warn_hyst (  // R9
    .sys_clk (sys_clk),
    .reset   (reset),
    .temp    (temp_j),
    .hot_r   (warn_hot)
  );

  pfs_filter #(.CNT_W(18), .N(TRIP_N)) u_warn_flt (  // R10
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (warn_hot),
    .dout_r  (ot_warn_r)
  );

  pfs_filter #(.CNT_W(18), .N(TRIP_N)) u_pg_flt (  // R12
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (pg_raw),
    .dout_r  (window_ok_signal)
  );

  assign q_oc  = q_vec[`PFS_EV_OC];
  assign q_ov  = q_vec[`PFS_EV_OV];
  assign q_uv  = q_vec[`PFS_EV_UV];
  assign q_ot  = q_vec[`PFS_EV_OT];
  assign q_trk = q_vec[`PFS_EV_TRK];

  wire       any_fault = q_oc | q_ov | q_uv | q_ot | q_trk;
  wire       lat_hit   = |(q_vec & latch_cfg_r);
  wire       ot_hold   = q_ot | ot_hot;

  // ==========================================================================
  // Turn-off sequencing
  always @(posedge sys_clk) begin
    if (reset) begin
      state_r        <= ST_RUN;
      shutdown_cmd_r <= 1'b0;
      retry_cnt_r    <= 24'h000000;
      cause_r        <= 5'h00;
    end else begin
      case (state_r)
        ST_RUN: begin
          retry_cnt_r <= 24'h000000;
          if (any_fault) begin
            shutdown_cmd_r <= 1'b1;
            cause_r        <= q_vec;
            state_r        <= lat_hit ? ST_LATCH : ST_WAIT;  // R13
          end
        end
        ST_WAIT: begin
          if (retry_cnt_r == RETRY_N - 1'b1) begin
            retry_cnt_r <= 24'h000000;
            // A hot die keeps the converter off for another period
            if (!ot_hold) begin  // R6
              shutdown_cmd_r <= 1'b0;
              state_r        <= ST_RUN;  // R13
            end
          end else begin
            retry_cnt_r <= retry_cnt_r + 1'b1;
          end
        end
        ST_LATCH: begin
          if (restart && !ot_hold) begin  // R13
            shutdown_cmd_r <= 1'b0;
            state_r        <= ST_RUN;
          end
        end
        default: begin
          state_r        <= ST_LATCH;
          shutdown_cmd_r <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Interrupt status: rising edges of qualified faults and the warning
  wire [5:0] flt_now = {ot_warn_r, q_vec};
  wire [5:0] ev_set  = flt_now & ~flt_d_r;
  wire [5:0] w1c     = (wr & sel[6]) ? pwdata[5:0] : 6'h00;

  always @(posedge sys_clk) begin
    if (reset) begin
      flt_d_r    <= 6'h00;
      int_stat_r <= 6'h00;
      irq_r      <= 1'b0;
    end else begin
      flt_d_r    <= flt_now;
      // A new event in the clearing cycle survives the clear
      int_stat_r <= (int_stat_r & ~w1c) | ev_set;
      irq_r      <= |(((int_stat_r & ~w1c) | ev_set) & int_mask_r);
    end
  end

  // ==========================================================================
  // Configuration writes
  always @(posedge sys_clk) begin
    if (reset) begin
      trk_en_r    <= 1'b0;  // R8
      pg_sel_r    <= 1'b0;  // R11
      oc_sel_r    <= `PFS_OC_SEL_RST;  // R1
      ov_sel_r    <= `PFS_OV_SEL_RST;  // R2
      uv_sel_r    <= `PFS_UV_SEL_RST;  // R4
      latch_cfg_r <= `PFS_LATCH_RST;  // R13
      int_mask_r  <= 6'h00;
    end else if (wr) begin
      if (sel[0]) begin
        trk_en_r <= pwdata[`PFS_CTRL_TRK_EN];
        pg_sel_r <= pwdata[`PFS_CTRL_PG_SEL];
      end
      // Out-of-range codes clamp to the top step rather than wrap
      if (sel[1]) begin
        oc_sel_r <= (pwdata[3:0] > `PFS_OC_SEL_MAX) ? `PFS_OC_SEL_MAX : pwdata[3:0];  // R1
      end
      if (sel[2]) begin
        ov_sel_r <= (pwdata[1:0] > `PFS_OV_SEL_MAX) ? `PFS_OV_SEL_MAX : pwdata[1:0];  // R2
      end
      if (sel[3]) begin
        uv_sel_r <= pwdata[1:0];
      end
      if (sel[4]) begin
        latch_cfg_r <= pwdata[4:0];
      end
      if (sel[7]) begin
        int_mask_r <= pwdata[5:0];
      end
    end
  end

  // ==========================================================================
  // APB answer: one wait state, then data, ready and error together
  reg [31:0] rdata;

  always @* begin
    rdata = 32'h00000000;
    case (1'b1)
      sel[0]: rdata = {29'h00000000, pg_sel_r, trk_en_r, 1'b0};
      sel[1]: rdata = {28'h0000000, oc_sel_r};
      sel[2]: rdata = {30'h00000000, ov_sel_r};
      sel[3]: rdata = {30'h00000000, uv_sel_r};
      sel[4]: rdata = {27'h0000000, latch_cfg_r};
      sel[5]: rdata = {16'h0000, 3'b000, cause_r, state_r, window_ok_signal, ot_warn_r, shutdown_cmd_r, 2'b00};
      sel[6]: rdata = {26'h0000000, int_stat_r};
      sel[7]: rdata = {26'h0000000, int_mask_r};
      default: rdata = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~(|sel);
      if (acc && !pwrite) begin
        prdata_r <= rdata;
      end
    end
  end

endmodule // pfs_supervisor

`default_nettype wire

// file: testbench/pfs_plant.sv
// Power stage and sensor model on the far side of the fault supervisor.
// Assumes the turn-off command is registered on sys_clk; the sensors read back one cycle late.
`default_nettype none

module pfs_plant (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Command and operating point
  input  wire logic        off,
  input  wire logic [11:0] v_tgt,
  input  wire logic [11:0] i_tgt,
  // Sensor readings
  output var  logic [11:0] v_out,
  output var  logic [11:0] i_out
);
  // =====
  // Output collapses while the stage is off, so a fault clears itself
  always_ff @(posedge sys_clk) begin
    v_out <= (reset | off) ? 12'h000 : v_tgt;
    i_out <= (reset | off) ? 12'h000 : i_tgt;
  end
endmodule // pfs_plant

`default_nettype wire

// file: testbench/pfs_supervisor_chk.sv
// Concurrent checks of the fault supervisor, bound to its top module.
// Sees only the top ports; measurements are synchronous to sys_clk.
`default_nettype none

module pfs_supervisor_chk #(
  parameter int OT_CYC = 200000
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              reset,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready_r,
  input wire logic              pslverr_r,
  // Measurements
  input wire logic [11:0]       i_meas,
  input wire logic [11:0]       i_rated,
  input wire logic [11:0]       v_meas,
  input wire logic [11:0]       v_set,
  input wire logic signed [7:0] temp_j,
  // Outputs
  input wire logic              shutdown_cmd_r,
  input wire logic              ot_warn_r,
  input wire logic              window_ok_signal,
  input wire logic              irq_r
);
  // =====
  // Run lengths; levels sit at the outer end of every setting so they hold for any register value
  logic [15:0] ov_cnt_r, oc_cnt_r, hot_cnt_r, cool_cnt_r, out_cnt_r;
  wire  logic  ov_q  = v_meas >= 12'h3E8 && v_meas * 100 >= v_set * 130;
  wire  logic  oc_q  = i_meas * 100 >= i_rated * 140;
  wire  logic  out_q = v_meas * 100 < v_set * 90 || v_meas * 100 > v_set * 110;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ov_cnt_r   <= 16'h0;
      oc_cnt_r   <= 16'h0;
      hot_cnt_r  <= 16'h0;
      cool_cnt_r <= 16'h0;
      out_cnt_r  <= 16'h0;
    end else begin
      ov_cnt_r   <= ov_q ? ov_cnt_r + 16'h1 : 16'h0;
      oc_cnt_r   <= oc_q ? oc_cnt_r + 16'h1 : 16'h0;
      hot_cnt_r  <= (temp_j >= 8'sh78) ? hot_cnt_r + 16'h1 : 16'h0;
      cool_cnt_r <= (temp_j <= 8'sh74) ? cool_cnt_r + 16'h1 : 16'h0;
      out_cnt_r  <= out_q ? out_cnt_r + 16'h1 : 16'h0;
    end
  end

  // =====
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  rst_quiet_a: assert property ($fell(reset) |-> !(pready_r | shutdown_cmd_r | ot_warn_r | irq_r))
    else $error("outputs not quiet after reset");
  rdy_pulse_a: assert property (pready_r |=> !pready_r)
    else $error("ready longer than one cycle");
  rdy_follow_a: assert property (psel && penable && !pready_r |=> pready_r && psel && penable)
    else $error("ready not one cycle after access");
  err_with_rdy_a: assert property (pslverr_r |-> pready_r)
    else $error("error without ready");
  ov_trip_a: assert property (ov_cnt_r >= 16'd615 |-> shutdown_cmd_r)
    else $error("overvoltage not shut down");
  oc_trip_a: assert property (oc_cnt_r >= 16'd615 |-> shutdown_cmd_r)
    else $error("overcurrent not shut down");
  ot_trip_a: assert property (hot_cnt_r >= OT_CYC + 5 |-> shutdown_cmd_r)
    else $error("overtemperature not shut down");
  warn_early_a: assert property ($rose(ot_warn_r) |-> hot_cnt_r >= 16'd595)
    else $error("warning raised early");
  warn_late_a: assert property (hot_cnt_r >= 16'd608 |-> ot_warn_r)
    else $error("warning not raised");
  warn_clear_a: assert property (cool_cnt_r >= 16'd615 |-> !ot_warn_r)
    else $error("warning not cleared");
  win_out_a: assert property (out_cnt_r >= 16'd615 |-> !window_ok_signal)
    else $error("power good outside window");
endmodule // pfs_supervisor_chk

bind pfs_supervisor pfs_supervisor_chk #(.OT_CYC(OT_CYC)) chk (.sys_clk, .reset, .psel, .penable, .pready_r,
  .pslverr_r, .i_meas, .i_rated, .v_meas, .v_set, .temp_j, .shutdown_cmd_r, .ot_warn_r, .window_ok_signal, .irq_r);

`default_nettype wire

// file: testbench/pfs_supervisor_test.sv
// Self-checking bench of the fault supervisor: register table, then trip, retry and latch cases.
// Assumes the plant model and the bound checker; one 100 MHz clock, short OT and retry counts.
`default_nettype none

module pfs_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, reset, psel, penable, pwrite, ramp_up, e;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, q, r;
  logic [11:0]       i_rated, v_set, v_ramp_ref, v_tgt, i_tgt;
  logic signed [7:0] temp_j;
  wire logic [11:0]  v_meas, i_meas;
  wire logic [31:0]  prdata_r;
  wire logic         pready_r, pslverr_r, shutdown_cmd_r, ot_warn_r, window_ok_signal, irq_r;
  int                n_fail = 0, tests_run = 0, cyc = 0;
  // Row: write flag, address, write data, expected read, expected error
  localparam logic [31:0] ROWS [18] = '{32'h00000000, 32'h004000A0, 32'h00800020, 32'h00C00000,
    32'h01000000, 32'h01800000, 32'h01C00000, 32'h10403030, 32'h1040F0A0, 32'h10803020, 32'h10800000,
    32'h10C03030, 32'h1103F1F0, 32'h11000000, 32'h11C1F1F0, 32'h10007060, 32'h10000000, 32'h12005001};

  pfs_supervisor #(.OT_CYC(20), .RETRY_CYC(700)) uut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready_r, .prdata_r, .pslverr_r, .i_meas, .i_rated, .v_meas, .v_set, .v_ramp_ref, .ramp_up,
    .temp_j, .shutdown_cmd_r, .ot_warn_r, .window_ok_signal, .irq_r);
  pfs_plant plant (.sys_clk, .reset, .off(shutdown_cmd_r), .v_tgt, .i_tgt, .v_out(v_meas), .i_out(i_meas));

  // =====
  // Tasks
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready_r !== 1'b1);
    q = prdata_r;
    e = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp(q, x);
  endtask
  function automatic logic sel(input int w);
    return (w == 0) ? shutdown_cmd_r : (w == 1) ? ot_warn_r : window_ok_signal;
  endfunction
  // Cycles until the chosen output reaches lv must land in lo..hi
  task automatic wt(input int w, input logic lv, input int lo, input int hi);
    int n;
    n = 0;
    while (sel(w) !== lv && n <= hi) begin
      @(posedge sys_clk);
      n++;
    end
    cmp(32'(n), (n < lo || n > hi) ? 32'(lo) : 32'(n));
  endtask
  task automatic stay(input int w, input logic lv, input int k);
    repeat (k) @(posedge sys_clk);
    cmp(32'(sel(w)), 32'(lv));
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d failures so far", s, n_fail);
  endtask
  task automatic print_verdict;
    $display("%0d comparisons, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // =====
  // Clock and timeout
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict;
    end
  end

  // =====
  // Sequence
  initial begin
    {reset, psel, penable, pwrite, ramp_up, paddr, pwdata} = {5'h10, 8'h00, 32'h0};
    {i_rated, v_set, v_ramp_ref, v_tgt, i_tgt} = {12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h1F4};
    temp_j = 8'sh19;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      r = ROWS[i];
      if (r[28]) apb(1'b1, r[27:20], {24'h0, r[19:12]});
      rd(r[27:20], {24'h0, r[11:4]});
      cmp(32'(e), 32'(r[0]));
    end
    done("registers");
    // Percentage under one volt: the absolute floor governs
    v_set <= 12'h2BC;
    v_tgt <= 12'h3B6;
    stay(0, 0, 700);
    v_tgt <= 12'h3F2;
    wt(0, 1, 595, 610);
    rd(8'h18, 32'h2);
    cmp(32'(irq_r), 32'h1);
    apb(1'b1, 8'h18, 32'h2);
    @(posedge sys_clk);
    cmp(32'(irq_r), 32'h0);
    {v_set, v_tgt} <= {12'h3E8, 12'h3E8};
    wt(0, 0, 680, 715);
    done("overvoltage");
    apb(1'b1, 8'h10, 32'h2);
    v_tgt <= 12'h514;
    wt(0, 1, 595, 610);
    v_tgt <= 12'h3E8;
    stay(0, 1, 700);
    apb(1'b1, 8'h00, 32'h1);
    wt(0, 0, 0, 5);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h18, 32'h3F);
    done("latching");
    apb(1'b1, 8'h08, 32'h2);
    v_tgt <= 12'h3A2;
    wt(2, 1, 0, 700);
    stay(2, 1, 700);
    apb(1'b1, 8'h00, 32'h4);
    wt(2, 0, 590, 610);
    v_tgt <= 12'h44C;
    wt(2, 1, 595, 610);
    v_tgt <= 12'h456;
    wt(2, 0, 595, 610);
    apb(1'b1, 8'h00, 32'h0);
    v_tgt <= 12'h370;
    wt(0, 1, 595, 610);
    v_tgt <= 12'h3E8;
    wt(0, 0, 680, 715);
    rd(8'h18, 32'h4);
    apb(1'b1, 8'h18, 32'h4);
    done("window and undervoltage");
    {ramp_up, v_tgt} <= {1'b1, 12'h2ED};
    stay(0, 0, 700);
    apb(1'b1, 8'h00, 32'h2);
    v_tgt <= 12'h2EE;
    stay(0, 0, 700);
    v_tgt <= 12'h2ED;
    wt(0, 1, 595, 610);
    {ramp_up, v_tgt} <= {1'b0, 12'h3E8};
    wt(0, 0, 680, 715);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h18, 32'h10);
    done("tracking");
    apb(1'b1, 8'h04, 32'h0);
    wt(0, 1, 590, 610);
    apb(1'b1, 8'h04, 32'hA);
    i_tgt <= 12'h56E;
    wt(0, 0, 680, 715);
    stay(0, 0, 700);
    i_tgt <= 12'h578;
    wt(0, 1, 595, 610);
    i_tgt <= 12'h1F4;
    wt(0, 0, 680, 715);
    apb(1'b1, 8'h18, 32'h1);
    done("overcurrent");
    temp_j <= 8'sh78;
    wt(0, 1, 20, 30);
    wt(1, 1, 565, 600);
    rd(8'h18, 32'h28);
    apb(1'b1, 8'h18, 32'h8);
    @(posedge sys_clk);
    cmp(32'(irq_r), 32'h0);
    temp_j <= 8'sh76;
    stay(1, 1, 700);
    cmp(32'(shutdown_cmd_r), 32'h1);
    temp_j <= 8'sh70;
    wt(1, 0, 595, 610);
    cmp(32'(shutdown_cmd_r), 32'h1);
    temp_j <= 8'sh6E;
    wt(0, 0, 20, 735);
    done("overtemperature");
    apb(1'b1, 8'h04, 32'h3);
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h04, 32'hA);
    done("reset");
    print_verdict;
  end
endmodule // pfs_supervisor_test

`default_nettype wire
